// file: shared/dtc_pkg.sv
// Constants, field layouts and carriers for the dual 16-bit timer block
package dtc_pkg;

  localparam int unsigned NCH = 2;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PRE_W = 6;

  // Register byte addresses
  localparam logic [3:0] REG_T0_LO = 4'h0;
  localparam logic [3:0] REG_T0_HI = 4'h1;
  localparam logic [3:0] REG_T1_LO = 4'h2;
  localparam logic [3:0] REG_T1_HI = 4'h3;
  localparam logic [3:0] REG_MODE0 = 4'h4;
  localparam logic [3:0] REG_MODE1 = 4'h5;
  localparam logic [3:0] REG_PRESC = 4'h6;
  localparam logic [3:0] REG_STAT = 4'h7;

  // Mode field encoding, fixed for this implementation
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_ALT = 2'h1;
  localparam logic [1:0] MODE_EVENT = 2'h2;
  localparam logic [1:0] MODE_MEAS = 2'h3;

  // Prescaler divide selections and their counter masks
  localparam logic [1:0] DIV_8 = 2'h0;
  localparam logic [1:0] DIV_16 = 2'h1;
  localparam logic [1:0] DIV_32 = 2'h2;
  localparam logic [5:0] MASK_8 = 6'h07;
  localparam logic [5:0] MASK_16 = 6'h0F;
  localparam logic [5:0] MASK_32 = 6'h1F;
  localparam logic [5:0] MASK_64 = 6'h3F;
  localparam logic [5:0] PRE_ONE = 6'h01;

  // Status byte bit positions
  localparam int unsigned ST_UF_LSB = 0;
  localparam int unsigned ST_PIN_LSB = 2;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic TOG_RST = 1'b1;

  typedef struct packed {
    logic halt;
    logic pol;
    logic [1:0] mode;
    logic [1:0] rsv;
    logic route;
    logic defer;
  } dtc_mode_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [1:0] div1;
    logic rsv_lo;
    logic sub0;
    logic [1:0] div0;
  } dtc_presc_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dtc_bus_t;

endpackage

// file: rtl/dtc_timer_top.sv
// Two 16-bit down-counting timers with reload latch and pulse modes, capture modes on the second timer only
`timescale 1ns/1ns
`default_nettype none

module dtc_timer_top (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Register port
  input wire dtc_pkg::dtc_bus_t bus_i,
  output logic [7:0] read_data_o,
  // Count sources and pins
  input wire logic alt_sub_clock_i,
  input wire logic first_counter_pin_i,
  output logic first_counter_pin_o,
  output logic first_counter_pin_oe_n_o,
  input wire logic second_counter_pin_i,
  output logic second_counter_pin_o,
  output logic second_counter_pin_oe_n_o,
  // Requests to the interrupt controller
  output logic [1:0] uf_req_o,
  output logic [1:0] pin_req_o
);

  localparam int unsigned NCH = dtc_pkg::NCH;

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Bus decode
  logic wr_stat;
  logic wr_presc;
  logic [NCH-1:0] wr_lo;
  logic [NCH-1:0] wr_hi;
  logic [NCH-1:0] rd_hi;
  logic [NCH-1:0] wr_mode;

  assign wr_stat = bus_i.wr && (bus_i.addr == dtc_pkg::REG_STAT);
  assign wr_presc = bus_i.wr && (bus_i.addr == dtc_pkg::REG_PRESC);

  dtc_pkg::dtc_mode_t mode_q [NCH];
  dtc_pkg::dtc_presc_t presc_q;
  dtc_pkg::dtc_mode_t wmode;
  assign wmode = dtc_pkg::dtc_mode_t'(bus_i.wdata);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= dtc_pkg::dtc_presc_t'(dtc_pkg::PRESC_RST);
    end else if (ce_i && wr_presc) begin
      presc_q <= dtc_pkg::dtc_presc_t'(bus_i.wdata);
    end
  end

  // Free-running prescaler shared by both timers
  logic [5:0] pre_q;
  logic sub_q;
  logic [NCH-1:0] pin_q;
  logic [NCH-1:0] pin_now;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] tick;
  logic sub_tick;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 6'h00;
      sub_q <= 1'b0;
      // Idle pins sit high, so no false edge follows reset
      pin_q <= '1;
    end else if (ce_i) begin
      pre_q <= pre_q + dtc_pkg::PRE_ONE;
      sub_q <= alt_sub_clock_i;
      pin_q <= pin_now;
    end
  end

  function automatic logic div_tick(input logic [1:0] sel,
                                    input logic [5:0] c);
    logic [5:0] m;
    case (sel)
      dtc_pkg::DIV_8: m = dtc_pkg::MASK_8;
      dtc_pkg::DIV_16: m = dtc_pkg::MASK_16;
      dtc_pkg::DIV_32: m = dtc_pkg::MASK_32;
      default: m = dtc_pkg::MASK_64;
    endcase
    return (c & m) == m;
  endfunction

  assign pin_now = {second_counter_pin_i, first_counter_pin_i};
  assign rise = pin_now & ~pin_q;
  assign fall = ~pin_now & pin_q;
  assign sub_tick = alt_sub_clock_i && !sub_q;
  // Sub-clock edges are sampled, so it must run well below ref_clk_i
  assign tick[0] = presc_q.sub0 ? sub_tick
                                : div_tick(presc_q.div0, pre_q);
  assign tick[1] = div_tick(presc_q.div1, pre_q);

  logic [15:0] cnt_q [NCH];
  logic [15:0] lat_q [NCH];
  logic [15:0] cap_q [NCH];
  logic [15:0] rd_hold_q [NCH];
  logic [15:0] view [NCH];
  logic [7:0] lo_hold_q [NCH];
  logic [NCH-1:0] src;
  logic [NCH-1:0] cap_raw;
  logic [NCH-1:0] pin_evt;
  logic [NCH-1:0] cnt_en;
  logic [NCH-1:0] cap;
  logic [NCH-1:0] wload;
  logic [NCH-1:0] uf;
  logic [NCH-1:0] tog_q;
  logic [NCH-1:0] oe_n_q;
  logic [NCH-1:0] uf_req_q;
  logic [NCH-1:0] pin_req_q;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam logic [3:0] A_LO = (i == 0) ? dtc_pkg::REG_T0_LO
                                           : dtc_pkg::REG_T1_LO;
    localparam logic [3:0] A_HI = (i == 0) ? dtc_pkg::REG_T0_HI
                                           : dtc_pkg::REG_T1_HI;
    localparam logic [3:0] A_MODE = (i == 0) ? dtc_pkg::REG_MODE0
                                             : dtc_pkg::REG_MODE1;
    dtc_pkg::dtc_mode_t m;
    logic drive;
    logic meas;

    assign m = mode_q[i];
    assign wr_lo[i] = bus_i.wr && (bus_i.addr == A_LO);
    assign wr_hi[i] = bus_i.wr && (bus_i.addr == A_HI);
    assign rd_hi[i] = bus_i.rd && (bus_i.addr == A_HI);
    assign wr_mode[i] = bus_i.wr && (bus_i.addr == A_MODE);

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        mode_q[i] <= dtc_pkg::dtc_mode_t'(dtc_pkg::MODE_RST);
      end else if (ce_i && wr_mode[i]) begin
        mode_q[i] <= wmode;
      end
    end

    // Count source, capture and pin event per mode
    always_comb begin
      src[i] = tick[i];
      cap_raw[i] = 1'b0;
      pin_evt[i] = 1'b0;
      case (m.mode)
        dtc_pkg::MODE_TIMER: begin
          src[i] = tick[i];
        end
        dtc_pkg::MODE_ALT: begin
          if (i == 1) begin
            cap_raw[i] = m.pol ? rise[i] : fall[i];
          end
        end
        dtc_pkg::MODE_EVENT: begin
          src[i] = m.pol ? fall[i] : rise[i];
        end
        dtc_pkg::MODE_MEAS: begin
          if (i == 0) begin
            src[i] = tick[i] && (pin_q[i] != m.pol);
            pin_evt[i] = m.pol ? rise[i] : fall[i];
          end else begin
            cap_raw[i] = rise[i] || fall[i];
          end
        end
        default: begin
          src[i] = 1'b0;
        end
      endcase
    end

    assign cnt_en[i] = src[i] && !m.halt;
    assign cap[i] = cap_raw[i] && !m.halt;
    assign wload[i] = wr_hi[i] && !m.defer;
    assign uf[i] = cnt_en[i] && (cnt_q[i] == dtc_pkg::CNT_ZERO) &&
                   !wload[i] && !cap[i];
    assign meas = (i == 1) && ((m.mode == dtc_pkg::MODE_ALT) ||
                               (m.mode == dtc_pkg::MODE_MEAS));
    assign view[i] = meas ? cap_q[i] : cnt_q[i];
    assign drive = (i == 0) ? (m.mode == dtc_pkg::MODE_ALT)
                            : ((m.mode == dtc_pkg::MODE_TIMER) && m.route);

    // Held low byte does not touch the latch until the high write
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        lo_hold_q[i] <= 8'h00;
      end else if (ce_i && wr_lo[i]) begin
        lo_hold_q[i] <= bus_i.wdata;
      end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        lat_q[i] <= dtc_pkg::CNT_RST;
      end else if (ce_i && wr_hi[i]) begin
        lat_q[i] <= {bus_i.wdata, lo_hold_q[i]};
      end
    end

    // Write load wins over capture, capture over counting
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q[i] <= dtc_pkg::CNT_RST;
      end else if (ce_i) begin
        if (wload[i]) begin
          cnt_q[i] <= {bus_i.wdata, lo_hold_q[i]};
        end else if (cap[i]) begin
          cnt_q[i] <= lat_q[i];
        end else if (cnt_en[i]) begin
          if (cnt_q[i] == dtc_pkg::CNT_ZERO) begin
            cnt_q[i] <= lat_q[i];
          end else begin
            cnt_q[i] <= cnt_q[i] - dtc_pkg::CNT_ONE;
          end
        end
      end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        cap_q[i] <= dtc_pkg::CNT_ZERO;
      end else if (ce_i && cap[i]) begin
        cap_q[i] <= cnt_q[i];
      end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        rd_hold_q[i] <= dtc_pkg::CNT_ZERO;
      end else if (ce_i && rd_hi[i]) begin
        rd_hold_q[i] <= view[i];
      end
    end

    // Mode write restarts the square wave from the inverse of its polarity bit
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        tog_q[i] <= dtc_pkg::TOG_RST;
        oe_n_q[i] <= 1'b1;
      end else if (ce_i) begin
        oe_n_q[i] <= !drive;
        if (wr_mode[i]) begin
          tog_q[i] <= !wmode.pol;
        end else if (uf[i]) begin
          tog_q[i] <= !tog_q[i];
        end
      end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        uf_req_q[i] <= 1'b0;
        pin_req_q[i] <= 1'b0;
      end else if (ce_i) begin
        uf_req_q[i] <= uf[i] || (uf_req_q[i] &&
          !(wr_stat && !bus_i.wdata[dtc_pkg::ST_UF_LSB + i]));
        pin_req_q[i] <= pin_evt[i] || cap[i] || (pin_req_q[i] &&
          !(wr_stat && !bus_i.wdata[dtc_pkg::ST_PIN_LSB + i]));
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  logic [7:0] rdata_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= dtc_pkg::RD_NONE;
    end else if (ce_i) begin
      if (bus_i.rd) begin
        case (bus_i.addr)
          dtc_pkg::REG_T0_LO: rdata_q <= rd_hold_q[0][7:0];
          dtc_pkg::REG_T0_HI: rdata_q <= view[0][15:8];
          dtc_pkg::REG_T1_LO: rdata_q <= rd_hold_q[1][7:0];
          dtc_pkg::REG_T1_HI: rdata_q <= view[1][15:8];
          dtc_pkg::REG_MODE0: rdata_q <= mode_q[0];
          dtc_pkg::REG_MODE1: rdata_q <= mode_q[1];
          dtc_pkg::REG_PRESC: rdata_q <= presc_q;
          dtc_pkg::REG_STAT: rdata_q <= {4'h0, pin_req_q, uf_req_q};
          default: rdata_q <= dtc_pkg::RD_NONE;
        endcase
      end else begin
        rdata_q <= dtc_pkg::RD_NONE;
      end
    end
  end

  assign read_data_o = rdata_q;
  assign first_counter_pin_o = tog_q[0];
  assign first_counter_pin_oe_n_o = oe_n_q[0];
  assign second_counter_pin_o = tog_q[1];
  assign second_counter_pin_oe_n_o = oe_n_q[1];
  assign uf_req_o = uf_req_q;
  assign pin_req_o = pin_req_q;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  logic [7:0] hold_lo0;
  assign hold_lo0 = rd_hold_q[0][7:0];

  sequence s_hi_read0;
    ce_i && rd_hi[0];
  endsequence
  sequence s_lo_read0;
    ce_i && bus_i.rd && (bus_i.addr == dtc_pkg::REG_T0_LO);
  endsequence

  underflow_reload_a: assert property (
    ce_i && uf[0] |=> cnt_q[0] == $past(lat_q[0]))
    else $error("counter not reloaded on underflow");
  count_step_a: assert property (
    ce_i && cnt_en[1] && !uf[1] && !wload[1] && !cap[1]
    |=> cnt_q[1] == $past(cnt_q[1]) - dtc_pkg::CNT_ONE)
    else $error("counter did not step down by one");
  uf_flag_a: assert property (
    ce_i && uf[1] |=> uf_req_o[1])
    else $error("underflow flag not set");
  hi_write_a: assert property (
    ce_i && wload[0] |=> cnt_q[0] == lat_q[0] &&
      lat_q[0] == {$past(bus_i.wdata), $past(lo_hold_q[0])})
    else $error("high write did not load latch and counter");
  defer_write_a: assert property (
    ce_i && wr_hi[0] && mode_q[0].defer && !cnt_en[0]
    |=> $stable(cnt_q[0]))
    else $error("deferred write disturbed the counter");
  halt_stop_a: assert property (
    ce_i && mode_q[1].halt && !wr_hi[1] |=> $stable(cnt_q[1]))
    else $error("halted timer kept counting");
  pulse_toggle_a: assert property (
    ce_i && uf[0] && !wr_mode[0] |=> tog_q[0] != $past(tog_q[0]))
    else $error("pulse output did not invert");
  capture_value_a: assert property (
    ce_i && cap[1] |=> cap_q[1] == $past(cnt_q[1]) ##0
      cnt_q[1] == $past(lat_q[1]) ##0 pin_req_o[1])
    else $error("capture did not store, reload and request");
  width_req_a: assert property (
    ce_i && pin_evt[0] |=> pin_req_o[0])
    else $error("pin request missing at width end");
  read_pair_a: assert property (
    s_hi_read0 ##1 s_lo_read0 |=> read_data_o == $past(hold_lo0))
    else $error("low read not from held copy");

endmodule

`default_nettype wire

// file: testbench/dtc_pin_model.sv
// Far-side model of the two counter pins with their pull-ups
`timescale 1ns/1ns
`default_nettype none
module dtc_pin_model (
  // Far-side drive requests
  input wire logic [1:0] ext_en_i,
  input wire logic [1:0] ext_lvl_i,
  // Block side of the pins
  input wire logic [1:0] blk_lvl_i,
  input wire logic [1:0] blk_oe_n_i,
  // Resolved pin levels
  output logic [1:0] pin_o
);
  // Block drive wins; a released, undriven pin floats up to one
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (!blk_oe_n_i[k])
        pin_o[k] = blk_lvl_i[k];
      else if (ext_en_i[k])
        pin_o[k] = ext_lvl_i[k];
      else
        pin_o[k] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_dtc_timer_top.sv
// Self-checking bench for the dual 16-bit timer block
`timescale 1ns/1ns
`default_nettype none
module tb_dtc_timer_top;
  logic ref_clk_i;
  logic reset_n_i;
  logic ce_i;
  logic alt_sub_clock_i;
  dtc_pkg::dtc_bus_t bus;
  logic [7:0] rdata;
  logic [1:0] pin_out;
  logic [1:0] pin_oe_n;
  logic [1:0] pin_lvl;
  logic [1:0] ext_en;
  logic [1:0] ext_lvl;
  logic [1:0] uf_req;
  logic [1:0] pin_req;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [15:0] v;
  logic [7:0] rows [4] = '{8'h10, 8'h50, 8'h30, 8'h90};
  logic [3:0] s_row = 4'b0010;
  logic [3:0] e1_row = 4'b0100;
  logic [3:0] e2_row = 4'b0111;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int cnt;

  dtc_timer_top dtc_timer_top_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .bus_i(bus), .read_data_o(rdata), .alt_sub_clock_i(alt_sub_clock_i),
    .first_counter_pin_i(pin_lvl[0]), .first_counter_pin_o(pin_out[0]),
    .first_counter_pin_oe_n_o(pin_oe_n[0]),
    .second_counter_pin_i(pin_lvl[1]), .second_counter_pin_o(pin_out[1]),
    .second_counter_pin_oe_n_o(pin_oe_n[1]),
    .uf_req_o(uf_req), .pin_req_o(pin_req)
  );

  dtc_pin_model dtc_pin_model_inst (
    .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .blk_lvl_i(pin_out),
    .blk_oe_n_i(pin_oe_n), .pin_o(pin_lvl)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang stops here; the whole sequence needs a few thousand cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // A gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    @(posedge ref_clk_i);
    d = rdata;
  endtask

  // High then low read back to back, each byte taken in its data cycle
  task automatic rd16(input int ch, output logic [15:0] r);
    bus.rd <= 1'b1;
    bus.addr <= dtc_pkg::REG_T0_HI + 4'(2 * ch);
    @(posedge ref_clk_i);
    bus.addr <= dtc_pkg::REG_T0_LO + 4'(2 * ch);
    @(posedge ref_clk_i);
    hi = rdata;
    bus.rd <= 1'b0;
    @(posedge ref_clk_i);
    lo = rdata;
    r = {hi, lo};
  endtask

  task automatic load(input int ch, input logic [15:0] d);
    wr(dtc_pkg::REG_T0_LO + 4'(2 * ch), d[7:0]);
    wr(dtc_pkg::REG_T0_HI + 4'(2 * ch), d[15:8]);
  endtask

  task automatic setup(input int ch, input logic [7:0] m,
                       input logic [15:0] d);
    wr(dtc_pkg::REG_MODE0 + 4'(ch), 8'h80);
    load(ch, d);
    wr(dtc_pkg::REG_MODE0 + 4'(ch), m);
  endtask

  task automatic wait_uf(input int ch, output int k);
    k = 0;
    while (uf_req[ch] !== 1'b1 && k < 2000) begin
      @(posedge ref_clk_i);
      k++;
    end
    check(16'(k < 2000), 16'h0001);
  endtask

  // Period from one flag rise to the next, the clear write included
  task automatic measure(input int ch, input logic [15:0] exp);
    wr(dtc_pkg::REG_STAT, 8'h00);
    wait_uf(ch, cnt);
    wr(dtc_pkg::REG_STAT, 8'h00);
    wait_uf(ch, cnt);
    check(16'(cnt + 2), exp);
  endtask

  // Two pulses on the sub-clock or on the pin of one timer
  task automatic pulses(input int ch, input logic sub);
    for (int e = 0; e < 2; e++) begin
      check(16'(uf_req[ch]), 16'h0000);
      alt_sub_clock_i <= sub;
      ext_lvl[ch] <= !sub;
      tick(4);
      alt_sub_clock_i <= 1'b0;
      ext_lvl[ch] <= 1'b0;
      tick(4);
    end
    check(16'(uf_req[ch]), 16'h0001);
  endtask

  initial begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    alt_sub_clock_i = 1'b0;
    bus = '0;
    ext_en = 2'b00;
    ext_lvl = 2'b00;
    tick(10);
    reset_n_i <= 1'b1;
    tick(3);
    // Reset contents, unmapped places read zero
    for (int a = 4; a < 10; a++) begin
      rd(4'(a), lo);
      check(16'(lo), 16'h0000);
    end
    check(16'(pin_oe_n), 16'h0003);
    // Byte order, holders, halt and deferred load
    wr(dtc_pkg::REG_MODE0, 8'h80);
    load(0, 16'h1234);
    rd16(0, v);
    check(v, 16'h1234);
    wr(dtc_pkg::REG_T0_LO, 8'h78);
    rd16(0, v);
    check(v, 16'h1234);
    wr(dtc_pkg::REG_T0_HI, 8'h56);
    tick(100);
    rd16(0, v);
    check(v, 16'h5678);
    wr(dtc_pkg::REG_MODE0, 8'h81);
    load(0, 16'h0005);
    rd(dtc_pkg::REG_T0_HI, hi);
    check(16'(hi), 16'h0056);
    wr(dtc_pkg::REG_MODE0, 8'h01);
    tick(50);
    rd(dtc_pkg::REG_T0_LO, lo);
    check(16'(lo), 16'h0078);
    // Every divider on both timers, reload value one
    for (int ch = 0; ch < 2; ch++) begin
      for (int d = 0; d < 4; d++) begin
        wr(dtc_pkg::REG_PRESC, 8'(ch == 0 ? d : d * 16));
        setup(ch, 8'h00, 16'h0001);
        measure(ch, 16'(16 << d));
      end
    end
    check(16'(pin_oe_n[1]), 16'h0001);
    // Sub-clock source: still clock means no count
    wr(dtc_pkg::REG_PRESC, 8'h04);
    setup(0, 8'h00, 16'h0001);
    wr(dtc_pkg::REG_STAT, 8'h00);
    tick(40);
    pulses(0, 1'b1);
    wr(dtc_pkg::REG_PRESC, 8'h00);
    // Clock enable low freezes the running count
    setup(0, 8'h00, 16'h0100);
    ce_i <= 1'b0;
    tick(400);
    ce_i <= 1'b1;
    rd16(0, v);
    check(16'(v > 16'h00F8), 16'h0001);
    // Toggle outputs, both polarities, both timers
    // Flags are cleared while halted, so the first wait sees one toggle
    for (int k = 0; k < 4; k++) begin
      wr(dtc_pkg::REG_MODE0 + 4'(k / 2), 8'h80);
      load(k / 2, 16'h0001);
      wr(dtc_pkg::REG_STAT, 8'h00);
      wr(dtc_pkg::REG_MODE0 + 4'(k / 2),
         (k / 2 == 0 ? 8'h10 : 8'h02) | 8'((k % 2) * 64));
      // Output enable follows the mode one cycle later
      tick(1);
      check(16'(pin_lvl[k / 2]), 16'(1 - k % 2));
      check(16'(pin_oe_n[k / 2]), 16'h0000);
      wait_uf(k / 2, cnt);
      check(16'(pin_lvl[k / 2]), 16'(k % 2));
    end
    // First timer width mode, then edge counting
    ext_en <= 2'b11;
    ext_lvl <= 2'b00;
    setup(0, 8'h30, 16'h00FF);
    wr(dtc_pkg::REG_STAT, 8'h00);
    tick(40);
    rd16(0, v);
    check(v, 16'h00FF);
    ext_lvl[0] <= 1'b1;
    tick(80);
    check(16'(pin_req[0]), 16'h0000);
    ext_lvl[0] <= 1'b0;
    tick(4);
    check(16'(pin_req[0]), 16'h0001);
    rd16(0, v);
    check(16'(v < 16'h00FF && v > 16'h00F0), 16'h0001);
    setup(0, 8'h20, 16'h0001);
    wr(dtc_pkg::REG_STAT, 8'h00);
    pulses(0, 1'b0);
    // Second timer capture modes, polarities and halt
    setup(1, 8'h90, 16'h0100);
    for (int r = 0; r < 4; r++) begin
      ext_lvl[1] <= s_row[r];
      tick(4);
      wr(dtc_pkg::REG_MODE1, rows[r]);
      wr(dtc_pkg::REG_STAT, 8'h00);
      ext_lvl[1] <= !s_row[r];
      tick(4);
      check(16'(pin_req[1]), 16'(e1_row[r]));
      wr(dtc_pkg::REG_STAT, 8'h00);
      ext_lvl[1] <= s_row[r];
      tick(4);
      check(16'(pin_req[1]), 16'(e2_row[r]));
      if (r == 0) begin
        rd16(1, v);
        check(16'(v < 16'h0100 && v > 16'h00F0), 16'h0001);
      end
    end
    // Second timer event mode, polarity one counts falling edges
    setup(1, 8'h60, 16'h0001);
    wr(dtc_pkg::REG_STAT, 8'h00);
    pulses(1, 1'b0);
    complete_run;
  end
endmodule
`default_nettype wire
